// ### src/anpgc_regs.sv
// Overview of operation
// - Register 0x0008 holds latest partner next page.
// - Bit 15 shows partner wants more pages.
// - Bit 14 read-only partner acknowledge flag.
// - Bit 13 message page flag, default one.
// - Bit 12 mirrors partner comply-acknowledge flag.
// - Bit 11 read-only, inverse of previous toggle.
// - Bits 10:0 page code, default null page.
// - Config bits 15:13 select transmitter test mode.
// - Config bit 12 enables manual master/slave.
// - Config bit 11 forces master or slave.
// - Config bit 10 advertises multi-port device.
// - Config bit 9 full duplex, strap default.
// - Config bit 8 half duplex, default one.
// - Config bit 7 runs diagnostics on link loss.
// - Config bits 6:0 read zero, ignore writes.
// - Partner next pages stored in register 8.
// - Page-received flag sets on page, clears on read.
`timescale 1ns/1ps
`default_nettype none

module anpgc_regs #(
    // One when the full duplex default comes from the strap pin.
    parameter bit FULL_DUPLEX_FROM_STRAP = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    // Management register access from the serial management engine.
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Next page word accepted by the arbitration logic.
    input wire logic i_page_valid,
    input wire logic [15:0] i_page_word,
    // Read of the expansion status word clears the page-received flag.
    input wire logic i_page_flag_read,
    output logic o_page_received,
    // Full duplex strap pin, sampled after reset release.
    input wire logic i_strap_full_duplex,
    // Link status from the link monitor in this clock domain.
    input wire logic i_link_up,
    // Configuration outputs to the gigabit datapath.
    output logic [2:0] o_test_mode,
    output logic o_ms_manual_en,
    output logic o_ms_force_master,
    output logic o_multi_port,
    output logic o_adv_full_duplex,
    output logic o_adv_half_duplex,
    output logic o_cable_diag_start
);

    // ****************************************************************
    // Elaboration-time check.
    // ****************************************************************
    // The register layout assumes 16-bit words and 5-bit addresses.
    if (anpgc_pkg::REG_W != 16 || anpgc_pkg::ADDR_W != 5) begin : g_width_check
        $error("Register bank needs 16-bit words and 5-bit addresses.");
    end

    // ****************************************************************
    // Register state.
    // ****************************************************************
    // Received next page register contents.
    logic [15:0] next_page_ff;
    logic [15:0] nxt_next_page;
    // Toggle bit carried by the previously exchanged link code word.
    logic prev_toggle_ff;
    logic nxt_prev_toggle;
    // Gigabit base configuration contents.
    logic [15:0] config_ff;
    logic [15:0] nxt_config;
    // Delayed page accept, raises the flag after the word is stored.
    logic page_stored_ff;
    logic nxt_page_stored;
    // Read data and its valid strobe.
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;

    // Write decode for each register.
    logic wr_next_page;
    logic wr_config;

    assign wr_next_page = i_reg_wr && (i_reg_addr == anpgc_pkg::ADDR_PARTNER_NEXT_PAGE);
    assign wr_config = i_reg_wr && (i_reg_addr == anpgc_pkg::ADDR_GIGABIT_BASE_CONFIG);

    // ****************************************************************
    // Strap synchroniser and capture.
    // ****************************************************************
    // Two-stage synchroniser for the strap pin.
    logic strap_meta_ff;
    logic strap_sync_ff;
    // Settling counter after reset release.
    logic [1:0] settle_ff;
    logic [1:0] nxt_settle;
    // Strap capture done.
    logic strap_done_ff;
    logic nxt_strap_done;
    // Strap is taken in this cycle.
    logic strap_take;

    // The strap pin is asynchronous to the management clock.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            strap_meta_ff <= 1'b0;
            strap_sync_ff <= 1'b0;
        end else begin
            strap_meta_ff <= i_strap_full_duplex;
            strap_sync_ff <= strap_meta_ff;
        end
    end

    // Wait until the synchroniser holds a true pin level, then capture once.
    always_comb begin
        nxt_settle = settle_ff;
        nxt_strap_done = strap_done_ff;
        strap_take = 1'b0;
        if (!strap_done_ff) begin
            if (settle_ff == anpgc_pkg::STRAP_SETTLE_CYCLES) begin
                strap_take = 1'b1;
                nxt_strap_done = 1'b1;
            end else begin
                nxt_settle = settle_ff + 2'h1;
            end
        end
    end

    // Register the strap capture state.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            settle_ff <= 2'h0;
            strap_done_ff <= 1'b0;
        end else begin
            settle_ff <= nxt_settle;
            strap_done_ff <= nxt_strap_done;
        end
    end

    // ****************************************************************
    // Received next page register.
    // ****************************************************************
    // A page accept from arbitration overrides a software write.
    always_comb begin
        nxt_next_page = next_page_ff;
        nxt_prev_toggle = prev_toggle_ff;
        nxt_page_stored = 1'b0;
        if (i_page_valid) begin
            // The whole word is loaded in one edge.
            nxt_next_page = i_page_word;
            // Bit 11 takes the inverse of the previous word's toggle.
            nxt_next_page[anpgc_pkg::NP_TOGGLE_BIT] = ~prev_toggle_ff;
            nxt_prev_toggle = i_page_word[anpgc_pkg::NP_TOGGLE_BIT];
            // The flag rises one edge after the word is visible.
            nxt_page_stored = 1'b1;
        end else if (wr_next_page) begin
            // Acknowledge and toggle bits are not writable.
            nxt_next_page = (next_page_ff & ~anpgc_pkg::NP_WR_MASK)
                | (i_reg_wdata & anpgc_pkg::NP_WR_MASK);
        end
    end

    // Register the next page state; reset gives the null message page.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            next_page_ff <= anpgc_pkg::NP_RESET;
            prev_toggle_ff <= 1'b1;
            page_stored_ff <= 1'b0;
        end else begin
            next_page_ff <= nxt_next_page;
            prev_toggle_ff <= nxt_prev_toggle;
            page_stored_ff <= nxt_page_stored;
        end
    end

    // Page-received flag, set on a stored page and cleared by its read.
    anpgc_sticky_flag u_page_flag (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_set(page_stored_ff),
        .i_clr(i_page_flag_read),
        .o_flag(o_page_received)
    );

    // ****************************************************************
    // Gigabit base configuration register.
    // ****************************************************************
    // Software writes the upper bits; the strap loads full duplex once.
    always_comb begin
        nxt_config = config_ff;
        if (wr_config) begin
            // Reserved bits stay zero whatever is written.
            nxt_config = (i_reg_wdata & anpgc_pkg::CFG_WR_MASK);
        end else if (strap_take && FULL_DUPLEX_FROM_STRAP) begin
            // Strapped default for full duplex advertisement.
            nxt_config[anpgc_pkg::CFG_ADV_FULL_BIT] = strap_sync_ff;
        end
    end

    // Register the configuration; reset advertises both duplexes.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            config_ff <= anpgc_pkg::CFG_RESET;
        end else begin
            config_ff <= nxt_config;
        end
    end

    // ****************************************************************
    // Automatic cable diagnostics on link loss.
    // ****************************************************************
    // Previous link status, for falling edge detection.
    logic link_prev_ff;
    logic nxt_link_prev;
    // Diagnostic start pulse.
    logic diag_start_ff;
    logic nxt_diag_start;

    // A link-down edge launches diagnostics only when enabled.
    always_comb begin
        nxt_link_prev = i_link_up;
        nxt_diag_start = link_prev_ff && !i_link_up
            && config_ff[anpgc_pkg::CFG_AUTO_DIAG_BIT];
    end

    // Register the link edge detector.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            link_prev_ff <= 1'b0;
            diag_start_ff <= 1'b0;
        end else begin
            link_prev_ff <= nxt_link_prev;
            diag_start_ff <= nxt_diag_start;
        end
    end

    // ****************************************************************
    // Register read path.
    // ****************************************************************
    // Read data is registered; unmapped addresses read as zero.
    always_comb begin
        nxt_rvalid = i_reg_rd;
        nxt_rdata = rdata_ff;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                anpgc_pkg::ADDR_PARTNER_NEXT_PAGE: begin
                    nxt_rdata = next_page_ff;
                end
                anpgc_pkg::ADDR_GIGABIT_BASE_CONFIG: begin
                    nxt_rdata = config_ff & anpgc_pkg::CFG_WR_MASK;
                end
                default: begin
                    nxt_rdata = 16'h0000;
                end
            endcase
        end
    end

    // Register the read answer.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign o_reg_rdata = rdata_ff;
    assign o_reg_rvalid = rvalid_ff;
    // Test mode selection straight from the register.
    assign o_test_mode = config_ff[anpgc_pkg::CFG_TEST_MODE_MSB:anpgc_pkg::CFG_TEST_MODE_LSB];
    // Manual master/slave enable.
    assign o_ms_manual_en = config_ff[anpgc_pkg::CFG_MS_MANUAL_BIT];
    // Forced role is master only while manual forcing is on.
    assign o_ms_force_master = config_ff[anpgc_pkg::CFG_MS_MANUAL_BIT]
        & config_ff[anpgc_pkg::CFG_MS_VALUE_BIT];
    // Port type advertisement.
    assign o_multi_port = config_ff[anpgc_pkg::CFG_PORT_TYPE_BIT];
    // Duplex advertisements.
    assign o_adv_full_duplex = config_ff[anpgc_pkg::CFG_ADV_FULL_BIT];
    assign o_adv_half_duplex = config_ff[anpgc_pkg::CFG_ADV_HALF_BIT];
    assign o_cable_diag_start = diag_start_ff;

endmodule

`default_nettype wire

// ### src/anpgc_pkg.sv
// ****************************************************************
// Shared constants for the next page and gigabit configuration bank.
// ****************************************************************
package anpgc_pkg;

    // Width of a management register word.
    localparam int unsigned REG_W = 16;
    // Width of a management register address.
    localparam int unsigned ADDR_W = 5;

    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    // Received next page word from the link partner.
    localparam logic [4:0] ADDR_PARTNER_NEXT_PAGE = 5'h08;
    // Gigabit base configuration.
    localparam logic [4:0] ADDR_GIGABIT_BASE_CONFIG = 5'h09;

    // ****************************************************************
    // Field positions of the received next page register.
    // ****************************************************************
    localparam int unsigned NP_MORE_PAGES_BIT = 15;
    localparam int unsigned NP_ACK_BIT = 14;
    localparam int unsigned NP_MESSAGE_PAGE_BIT = 13;
    localparam int unsigned NP_COMPLY_ACK_BIT = 12;
    localparam int unsigned NP_TOGGLE_BIT = 11;
    localparam int unsigned NP_CODE_MSB = 10;
    localparam int unsigned NP_CODE_LSB = 0;

    // Reset value: message page set, code field holds the null page.
    localparam logic [15:0] NP_RESET = 16'h2001;
    // Bits that software may write; acknowledge and toggle are read-only.
    localparam logic [15:0] NP_WR_MASK = 16'hb7ff;

    // ****************************************************************
    // Field positions of the gigabit base configuration register.
    // ****************************************************************
    localparam int unsigned CFG_TEST_MODE_MSB = 15;
    localparam int unsigned CFG_TEST_MODE_LSB = 13;
    localparam int unsigned CFG_MS_MANUAL_BIT = 12;
    localparam int unsigned CFG_MS_VALUE_BIT = 11;
    localparam int unsigned CFG_PORT_TYPE_BIT = 10;
    localparam int unsigned CFG_ADV_FULL_BIT = 9;
    localparam int unsigned CFG_ADV_HALF_BIT = 8;
    localparam int unsigned CFG_AUTO_DIAG_BIT = 7;

    // Reset value with both duplex abilities advertised.
    localparam logic [15:0] CFG_RESET = 16'h0300;
    // Bits 6:0 are reserved: writes are dropped and reads return zero.
    localparam logic [15:0] CFG_WR_MASK = 16'hff80;

    // Cycles after reset release before the synchronised strap is valid.
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

    // Transmitter test mode selections.
    typedef enum logic [2:0] {
        TM_NORMAL = 3'b000,
        TM_WAVEFORM = 3'b001,
        TM_JITTER_MASTER = 3'b010,
        TM_JITTER_SLAVE = 3'b011,
        TM_DISTORTION = 3'b100,
        TM_SCRAMBLED_IDLE = 3'b101,
        TM_REPEAT_0001 = 3'b110,
        TM_PULSE_63_ZEROS = 3'b111
    } anpgc_test_mode_t;

endpackage

// ### src/anpgc_sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Sticky flag: set by hardware, cleared by a read; a set wins.
// ****************************************************************
module anpgc_sticky_flag (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_set,
    input wire logic i_clr,
    output logic o_flag
);

    // Stored flag.
    logic flag_ff;
    // Next value of the flag.
    logic nxt_flag;

    // An event in the clearing cycle keeps the flag set.
    always_comb begin
        nxt_flag = flag_ff;
        if (i_set) begin
            nxt_flag = 1'b1;
        end else if (i_clr) begin
            nxt_flag = 1'b0;
        end
    end

    // Register the flag.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign o_flag = flag_ff;

endmodule

`default_nettype wire

// ### tb/anpgc_regs_props.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Port checker for the next page and gigabit configuration bank.
// ****************************************************************
module anpgc_regs_props #(
    parameter bit FULL_DUPLEX_FROM_STRAP = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic i_page_valid,
    input wire logic [15:0] i_page_word,
    input wire logic i_page_flag_read,
    input wire logic o_page_received,
    input wire logic i_strap_full_duplex,
    input wire logic i_link_up,
    input wire logic [2:0] o_test_mode,
    input wire logic o_ms_manual_en,
    input wire logic o_ms_force_master,
    input wire logic o_multi_port,
    input wire logic o_adv_full_duplex,
    input wire logic o_adv_half_duplex,
    input wire logic o_cable_diag_start
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // High for a write to the configuration register.
    logic cfg_wr;
    assign cfg_wr = i_reg_wr && (i_reg_addr == anpgc_pkg::ADDR_GIGABIT_BASE_CONFIG);

    property p_rvalid; 1'b1 |=> (o_reg_rvalid == $past(i_reg_rd)); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid not one cycle after read");
    property p_rdata_hold; !o_reg_rvalid |-> $stable(o_reg_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
    property p_rsvd; o_reg_rvalid && $past(i_reg_addr) == 5'h09 |-> o_reg_rdata[6:0] == 7'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved config bits read nonzero");
    property p_tm; cfg_wr |=> o_test_mode == $past(i_reg_wdata[15:13]); endproperty
    a_tm: assert property (p_tm) else $error("test mode not taken from write");
    property p_man; cfg_wr |=> o_ms_manual_en == $past(i_reg_wdata[12]); endproperty
    a_man: assert property (p_man) else $error("manual enable not taken from write");
    property p_force; cfg_wr |=> o_ms_force_master
        == ($past(i_reg_wdata[12]) && $past(i_reg_wdata[11]));
    endproperty
    a_force: assert property (p_force) else $error("forced master wrong");
    property p_port; cfg_wr |=> o_multi_port == $past(i_reg_wdata[10]); endproperty
    a_port: assert property (p_port) else $error("port type not taken from write");
    property p_full; cfg_wr |=> o_adv_full_duplex == $past(i_reg_wdata[9]); endproperty
    a_full: assert property (p_full) else $error("full duplex advert wrong");
    property p_half; cfg_wr |=> o_adv_half_duplex == $past(i_reg_wdata[8]); endproperty
    a_half: assert property (p_half) else $error("half duplex advert wrong");
    property p_diag; o_cable_diag_start |-> !$past(i_link_up) && $past(i_link_up, 2); endproperty
    a_diag: assert property (p_diag) else $error("diagnostic start without link loss");
    property p_flag; i_page_valid |=> ##1 o_page_received; endproperty
    a_flag: assert property (p_flag) else $error("page flag not raised");
    property p_flag_cause; $rose(o_page_received) |-> $past(i_page_valid, 2); endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("page flag rose early");

    c_page: cover property (i_page_valid ##2 o_page_received);
    c_diag: cover property (o_cable_diag_start);
    c_cfg: cover property (cfg_wr ##1 o_ms_force_master);
endmodule

bind anpgc_regs anpgc_regs_props #(.FULL_DUPLEX_FROM_STRAP(FULL_DUPLEX_FROM_STRAP)) i_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_page_valid(i_page_valid), .i_page_word(i_page_word),
    .i_page_flag_read(i_page_flag_read), .o_page_received(o_page_received),
    .i_strap_full_duplex(i_strap_full_duplex), .i_link_up(i_link_up),
    .o_test_mode(o_test_mode), .o_ms_manual_en(o_ms_manual_en),
    .o_ms_force_master(o_ms_force_master), .o_multi_port(o_multi_port),
    .o_adv_full_duplex(o_adv_full_duplex), .o_adv_half_duplex(o_adv_half_duplex),
    .o_cable_diag_start(o_cable_diag_start));

`default_nettype wire

// ### tb/anpgc_link_partner.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Link partner model: delivers next page words and link status.
// ****************************************************************
module anpgc_link_partner (
    input wire logic i_clk,
    output logic o_page_valid,
    output logic [15:0] o_page_word,
    output logic o_link_up
);
    // Idle: no page offered, link up.
    initial begin
        o_page_valid = 1'b0;
        o_page_word = 16'h0000;
        o_link_up = 1'b1;
    end

    // Offers one word for one cycle; the released word line shows its inverse.
    task automatic send_page(input logic [15:0] w);
        @(posedge i_clk);
        o_page_valid <= 1'b1;
        o_page_word <= w;
        @(posedge i_clk);
        o_page_valid <= 1'b0;
        o_page_word <= ~w;
    endtask

    // Changes the link status just after a clock edge.
    task automatic set_link(input logic up);
        @(posedge i_clk);
        o_link_up <= up;
    endtask
endmodule

`default_nettype wire

// ### tb/tb_anpgc_regs.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Self-checking bench for the next page and gigabit configuration bank.
// ****************************************************************
module tb_anpgc_regs;
    logic i_clk, i_rst, i_reg_wr, i_reg_rd, o_reg_rvalid, page_valid, flag_rd, o_page_received;
    logic link_up, man, force_m, multi, full, half, diag, strap;
    logic [4:0] i_reg_addr;
    logic [15:0] i_reg_wdata, o_reg_rdata, page_word, w, cfg_outs, exp_outs;
    logic [2:0] tmode;
    int miscompares = 0;
    int n_checks = 0;
    // Configuration outputs packed in the register's bit layout.
    assign cfg_outs = {tmode, man, force_m, multi, full, half, 8'h00};

    // 40 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // The strapped variant is built, so the full duplex default follows the strap pin.
    anpgc_regs #(.FULL_DUPLEX_FROM_STRAP(1'b1)) i_anpgc_regs (.i_clk(i_clk), .i_rst(i_rst),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
        .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_page_valid(page_valid),
        .i_page_word(page_word), .i_page_flag_read(flag_rd), .o_page_received(o_page_received),
        .i_strap_full_duplex(strap), .i_link_up(link_up), .o_test_mode(tmode),
        .o_ms_manual_en(man), .o_ms_force_master(force_m), .o_multi_port(multi),
        .o_adv_full_duplex(full), .o_adv_half_duplex(half), .o_cable_diag_start(diag));
    anpgc_link_partner i_anpgc_link_partner (.i_clk(i_clk), .o_page_valid(page_valid),
        .o_page_word(page_word), .o_link_up(link_up));

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One write strobe; returns once the write edge has landed.
    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        #1;
    endtask

    // One read strobe; data and valid are looked at in the answer cycle.
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string msg);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk({15'h0000, o_reg_rvalid}, 16'h0001, "read valid");
        chk(o_reg_rdata, exp, msg);
    endtask

    // Waits a clock and checks a one-bit output once it has settled.
    task automatic bit_chk(input logic got_sel, input logic exp, input string msg);
        @(posedge i_clk);
        #1;
        chk({15'h0000, (got_sel ? diag : o_page_received)}, {15'h0000, exp}, msg);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the fewer than a hundred cycles the tests need.
    initial begin
        #50us;
        miscompares++;
        finish_test();
    end

    // Main test sequence.
    initial begin
        i_rst = 1'b1;
        i_reg_addr = 5'h00;
        i_reg_wr = 1'b0;
        i_reg_wdata = 16'h0000;
        i_reg_rd = 1'b0;
        flag_rd = 1'b0;
        // Strap pin low: full duplex is not advertised once the strap is taken.
        strap = 1'b0;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        rd_chk(5'h08, 16'h2001, "next page reset");
        rd_chk(5'h09, 16'h0100, "config reset");
        chk(cfg_outs, 16'h0100, "config outputs reset");
        reg_write(5'h1f, 16'hffff);
        rd_chk(5'h1f, 16'h0000, "unmapped read");
        rd_chk(5'h09, 16'h0100, "config after unmapped write");
        $display("test reset done");

        i_anpgc_link_partner.send_page(16'hf855);
        bit_chk(1'b0, 1'b1, "page flag set");
        rd_chk(5'h08, 16'hf055, "first page");
        @(posedge i_clk);
        flag_rd <= 1'b1;
        @(posedge i_clk);
        flag_rd <= 1'b0;
        bit_chk(1'b0, 1'b0, "page flag cleared");
        i_anpgc_link_partner.send_page(16'h0000);
        // A flag read in the cycle the page sets the flag must not clear it.
        flag_rd <= 1'b1;
        @(posedge i_clk);
        flag_rd <= 1'b0;
        bit_chk(1'b0, 1'b1, "set beats clear");
        rd_chk(5'h08, 16'h0000, "second page");
        i_anpgc_link_partner.send_page(16'h0123);
        rd_chk(5'h08, 16'h0923, "third page");
        reg_write(5'h08, 16'hffff);
        rd_chk(5'h08, 16'hbfff, "read-only page bits kept");
        reg_write(5'h08, 16'h0000);
        rd_chk(5'h08, 16'h0800, "page bits cleared");
        $display("test next page done");

        for (int i = 0; i < 8; i++) begin
            w = {i[2:0], i[0], i[1], i[2], ~i[0], i[1], i[0], 7'h7f};
            reg_write(5'h09, w);
            exp_outs = {w[15:12], w[12] & w[11], w[10:8], 8'h00};
            chk(cfg_outs, exp_outs, "config outputs");
            rd_chk(5'h09, w & 16'hff80, "config readback");
        end
        $display("test config done");

        reg_write(5'h09, 16'h0380);
        i_anpgc_link_partner.set_link(1'b0);
        bit_chk(1'b1, 1'b1, "diag start");
        bit_chk(1'b1, 1'b0, "diag start one cycle");
        i_anpgc_link_partner.set_link(1'b1);
        reg_write(5'h09, 16'h0300);
        i_anpgc_link_partner.set_link(1'b0);
        bit_chk(1'b1, 1'b0, "no diag when disabled");
        i_anpgc_link_partner.set_link(1'b1);
        $display("test diag done");
        finish_test();
    end
endmodule

`default_nettype wire
